// *** src/gfa_pkg.sv ***
package gfa_pkg;
	// ==================================================================
	// Clock and timebase
	// ==================================================================
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [9:0] MS_PER_SEC = 10'd1000;
	localparam logic [9:0] HALF_SEC_MS = 10'd500;
	localparam logic [9:0] QUARTER_SEC_MS = 10'd250;
	localparam logic [9:0] THREE_QUARTER_MS = 10'd750;
	localparam logic [9:0] CHIRP_MS = 10'd50;
	localparam logic [9:0] DBL_ON_MS = 10'd100;
	localparam logic [9:0] DBL_GAP_END_MS = 10'd200;
	localparam logic [9:0] DBL_END_MS = 10'd300;
	// ==================================================================
	// Durations in seconds
	// ==================================================================
	localparam logic [2:0] REMIND_PERIOD_S = 3'd5;
	localparam logic [11:0] LINK_ALARM_S = 12'd60;
	localparam logic [11:0] RUN_HOLD_S = 12'd300;
	localparam logic [11:0] SUPV_TIMEOUT_S = 12'd3600;
	// ==================================================================
	// Input vector positions
	// ==================================================================
	localparam int IN_STOP = 0;
	localparam int IN_RESET = 1;
	localparam int IN_EMER = 2;
	localparam int IN_DUAL = 3;
	localparam int IN_LINK_OK = 4;
	localparam int IN_PEER_ENTRAP = 5;
	localparam int IN_PEER_FW = 6;
	localparam int IN_RUN_EXP = 7;
	localparam int IN_OPENING = 8;
	localparam int IN_MOVING = 9;
	localparam int IN_FULL_OPEN = 10;
	localparam int IN_OBSTR = 11;
	localparam int IN_LIMIT = 12;
	localparam int IN_CMD = 13;
	localparam int IN_MAINS_LOW = 14;
	localparam int IN_MAINS_LOST = 15;
	localparam int IN_BATT_LOW = 16;
	localparam int IN_BATT_OK = 17;
	localparam int IN_NV = 18;
	localparam int IN_MOTOR = 19;
	localparam int IN_DC_MISMATCH = 20;
	localparam int IN_IMM_PF = 21;
	localparam int IN_PRESTART = 22;
	localparam int IN_SCALARS = 23;
	// ==================================================================
	// Display codes
	// ==================================================================
	localparam logic [7:0] FC_DD = 8'h00;
	localparam logic [7:0] FC_D1 = 8'h01;
	localparam logic [7:0] FC_02 = 8'h02;
	localparam logic [7:0] FC_D3 = 8'h03;
	localparam logic [7:0] FC_DH = 8'h04;
	localparam logic [7:0] FC_05 = 8'h05;
	localparam logic [7:0] FC_06 = 8'h06;
	localparam logic [7:0] FC_DT = 8'h07;
	localparam logic [7:0] FC_08 = 8'h08;
	localparam logic [7:0] FC_09 = 8'h09;
	localparam logic [7:0] FC_ID = 8'h10;
	localparam logic [7:0] FC_11 = 8'h11;
	localparam logic [7:0] FC_12 = 8'h12;
	localparam logic [7:0] FC_13 = 8'h13;
	localparam logic [7:0] FC_H = 8'he0;
endpackage : gfa_pkg

// *** src/gfa_sync.sv ***
// ======================================================================
// Two-stage synchroniser for a vector of asynchronous pins
// ======================================================================
module gfa_sync #(
	parameter int W = 1
) (
	input wire logic clock, // System clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic [W-1:0] d, // Asynchronous inputs.
	output logic [W-1:0] q // Synchronised outputs.
);
	logic [W-1:0] meta_r;

	// The first stage feeds only the second stage, never any logic.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : gfa_sync

// *** src/gfa_tick.sv ***
// ======================================================================
// Millisecond tick divider
// ======================================================================
module gfa_tick #(
	parameter int CYCLES = 100000
) (
	input wire logic clock, // System clock.
	input wire logic rst_n, // Reset, active low.
	output logic tick // Pulse every CYCLES clocks.
);
	localparam int CW = $clog2(CYCLES);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
	logic [CW-1:0] cnt_r;

	initial begin
		if (CYCLES < 2) $error("gfa_tick: CYCLES below 2");
	end

	// Free-running divider; the pulse marks the wrap.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (cnt_r == LAST);
			cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
		end
	end
endmodule : gfa_tick

// *** src/gfa_fault_manager.sv ***
// Behaviour
// - reset clears faults only, never starts motion.
// - link loss blinks lamp 1 Hz, blocks ordinary motion.
// - link loss shows D3, lamp, one-minute alarm.
// - supervise transmitters: battery, tamper, hourly report.
// - trouble doubles the pre-start beep rate.
// - trouble doubles run alarm, holds five minutes.
// - trouble while idle chirps every five seconds.
// - trouble beeper changes vanish when trouble clears.
// - run-time expiry locks out like entrapment.
// - after clearing, double beep until next operation.
// - expiry opening shows D1, closing 02, lamp.
// - two reversals show DD, alarm, disabled.
// - emergency full open shows DH until stop.
// - battery low on mains loss, fail action, 05.
// - peer entrapment shows 06 and disables.
// - low mains shows DT, disabled until normal.
// - command during entrapment shows 08 until stop.
// - firmware 09, settings ID, motor 12 disable.
// - DC motor mismatch 11, retried next command.
// - mains loss in immediate mode shows 13.
// - expiry on battery shows H until recovery.
// - two obstruction triggers enter entrapment lockout.
module gfa_fault_manager
	import gfa_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES,
	parameter int NXMTR = 4
) (
	input wire logic clock, // System clock, 100 MHz.
	input wire logic rstn, // Async reset, active low.
	input wire logic stop_btn, // Stop press.
	input wire logic reset_btn, // Reset press.
	input wire logic emergency_open_input, // Emergency-open request.
	input wire logic dual_gate_enable, // Paired install.
	input wire logic peer_link_ok, // Peer link healthy.
	input wire logic peer_entrapment, // Peer entrapped.
	input wire logic peer_fw_mismatch, // Peer firmware bad.
	input wire logic run_time_expired, // Run timer expired.
	input wire logic gate_opening, // Travelling open.
	input wire logic gate_moving, // Motor running.
	input wire logic gate_fully_open, // Open limit reached.
	input wire logic obstruction_trig, // Obstruction event.
	input wire logic limit_reached, // Travel limit.
	input wire logic command_in, // User command.
	input wire logic mains_low, // Mains below normal.
	input wire logic mains_lost, // Mains absent.
	input wire logic batt_below_min, // Battery below 21.6 V.
	input wire logic batt_above_recover, // Battery above 24 V.
	input wire logic nv_fault, // Settings memory problem.
	input wire logic motor_fault, // Motor failure.
	input wire logic dc_motor_mismatch, // DC motor check failed.
	input wire logic immediate_pf_mode, // Immediate power-fail mode.
	input wire logic prestart_active, // Pre-start warning.
	input wire logic [NXMTR-1:0] xmtr_enrolled, // Slot in use.
	input wire logic [NXMTR-1:0] xmtr_report, // Status report, toggles.
	input wire logic [NXMTR-1:0] xmtr_low_batt, // Low battery.
	input wire logic [NXMTR-1:0] xmtr_tamper, // Case open.
	output logic fault_show, // Code displayed.
	output logic [7:0] fault_code, // Displayed fault code.
	output logic link_lamp, // Peer link indicator.
	output logic run_limit_lamp, // Run-limit indicator.
	output logic beeper, // Sounder drive.
	output logic gate_enable, // Ordinary motion permitted.
	output logic emergency_enable, // Emergency motion allowed.
	output logic motor_stop, // Force motor off.
	output logic failsafe_act // Power-fail action.
);
	localparam int NIN = IN_SCALARS + 4 * NXMTR;

	initial begin
		if (NXMTR < 1 || NXMTR > 16) $error("gfa_fault_manager: NXMTR out of range");
	end

	// ==================================================================
	// Reset, pin synchronisation and edges
	// ==================================================================
	logic rst_meta_r, rst_n;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rst_meta_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n <= rst_meta_r;
		end
	end

	logic [NIN-1:0] pins, s, s_prev_r, rise;
	assign pins = {xmtr_enrolled, xmtr_tamper, xmtr_low_batt, xmtr_report, prestart_active,
		immediate_pf_mode, dc_motor_mismatch, motor_fault, nv_fault, batt_above_recover,
		batt_below_min, mains_lost, mains_low, command_in, limit_reached,
		obstruction_trig, gate_fully_open, gate_moving, gate_opening, run_time_expired,
		peer_fw_mismatch, peer_entrapment, peer_link_ok, dual_gate_enable,
		emergency_open_input, reset_btn, stop_btn};

	gfa_sync #(.W(NIN)) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.d(pins),
		.q(s)
	);

	// Edge history is taken from the second stage only.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) s_prev_r <= '0;
		else s_prev_r <= s;
	end
	assign rise = s & ~s_prev_r;

	logic stop_p, reset_p, clr_p, cmd_p, moving_stop_p, link_lost;
	assign stop_p = rise[IN_STOP];
	assign reset_p = rise[IN_RESET];
	assign clr_p = stop_p | reset_p;
	assign cmd_p = rise[IN_CMD];
	assign moving_stop_p = ~s[IN_MOVING] & s_prev_r[IN_MOVING];
	assign link_lost = s[IN_DUAL] & ~s[IN_LINK_OK];

	// ==================================================================
	// Timebase: ms tick, second and five-second phase
	// ==================================================================
	logic ms_tick, sec_tick;
	logic [9:0] ms_r;
	logic [2:0] sec5_r;
	gfa_tick #(.CYCLES(TICK_CYC)) u_tick (
		.clock(clock),
		.rst_n(rst_n),
		.tick(ms_tick)
	);
	assign sec_tick = ms_tick && (ms_r == MS_PER_SEC - 10'd1);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ms_r <= '0;
			sec5_r <= '0;
		end else if (ms_tick) begin
			ms_r <= sec_tick ? '0 : ms_r + 10'd1;
			if (sec_tick) sec5_r <= (sec5_r == REMIND_PERIOD_S - 3'd1) ? '0 : sec5_r + 3'd1;
		end
	end

	// ==================================================================
	// Transmitter supervision
	// ==================================================================
	logic [NXMTR-1:0] xmtr_bad;
	generate
		for (genvar gi = 0; gi < NXMTR; gi++) begin : g_xmtr
			logic [11:0] silent_r;
			logic rpt_p;
			// A report arrives as a toggle of its level, so both edges count.
			assign rpt_p = s[IN_SCALARS + gi] ^ s_prev_r[IN_SCALARS + gi];
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) silent_r <= '0;
				else if (!s[IN_SCALARS + 3 * NXMTR + gi] || rpt_p)
					silent_r <= '0;
				else if (sec_tick && silent_r != SUPV_TIMEOUT_S) silent_r <= silent_r + 12'd1;
			end
			assign xmtr_bad[gi] = s[IN_SCALARS + 3 * NXMTR + gi] && (s[IN_SCALARS + NXMTR + gi] ||
				s[IN_SCALARS + 2 * NXMTR + gi] || silent_r == SUPV_TIMEOUT_S);
		end
	endgenerate

	logic trouble;
	assign trouble = |xmtr_bad;

	// ==================================================================
	// Entrapment, run-time and emergency lockouts
	// ==================================================================
	logic obstr_seen_r, entrap_r, runlim_r, runlim_open_r, run_h_r, remind_r, dh_r, e08_r;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			obstr_seen_r <= 1'b0;
			entrap_r <= 1'b0;
		end else begin
			if (rise[IN_OBSTR]) obstr_seen_r <= 1'b1;
			else if (rise[IN_LIMIT] || clr_p) obstr_seen_r <= 1'b0;
			if (rise[IN_OBSTR] && obstr_seen_r) entrap_r <= 1'b1;
			else if (clr_p) entrap_r <= 1'b0;
		end
	end

	// Expiry on battery is H; else a direction-coded lockout.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			runlim_r <= 1'b0;
			runlim_open_r <= 1'b0;
			run_h_r <= 1'b0;
			remind_r <= 1'b0;
		end else begin
			if (rise[IN_RUN_EXP] && s[IN_MAINS_LOST]) run_h_r <= 1'b1;
			else if (s[IN_BATT_OK]) run_h_r <= 1'b0;
			if (rise[IN_RUN_EXP] && !s[IN_MAINS_LOST]) begin
				runlim_r <= 1'b1;
				runlim_open_r <= s[IN_OPENING];
			end else if (clr_p) begin
				runlim_r <= 1'b0;
			end
			if (runlim_r && clr_p) remind_r <= 1'b1;
			else if (rise[IN_MOVING]) remind_r <= 1'b0;
		end
	end

	// DH and 08 lockouts; only a stop press clears them.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dh_r <= 1'b0;
			e08_r <= 1'b0;
		end else begin
			if (s[IN_EMER] && rise[IN_FULL_OPEN]) dh_r <= 1'b1;
			else if (stop_p) dh_r <= 1'b0;
			if (cmd_p && entrap_r) e08_r <= 1'b1;
			else if (stop_p) e08_r <= 1'b0;
		end
	end

	// ==================================================================
	// Power, motor and link conditions
	// ==================================================================
	logic b05_r, mm_r, link_alarm_r;
	logic [11:0] link_s_r, hold_s_r;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			b05_r <= 1'b0;
			mm_r <= 1'b0;
		end else begin
			if (s[IN_MAINS_LOST] && s[IN_BATT_LOW]) b05_r <= 1'b1;
			else if (s[IN_BATT_OK]) b05_r <= 1'b0;
			// A command clears the mismatch so the move retries the check.
			if (rise[IN_DC_MISMATCH]) mm_r <= 1'b1;
			else if (cmd_p) mm_r <= 1'b0;
		end
	end

	// One-minute link alarm; a stop press silences it.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			link_alarm_r <= 1'b0;
			link_s_r <= '0;
		end else if (link_lost && s_prev_r[IN_DUAL] && s_prev_r[IN_LINK_OK]) begin
			link_alarm_r <= 1'b1;
			link_s_r <= '0;
		end else if (stop_p || !link_lost || link_s_r == LINK_ALARM_S) begin
			link_alarm_r <= 1'b0;
		end else if (sec_tick) begin
			link_s_r <= link_s_r + 12'd1;
		end
	end

	// Run alarm hold after a stop while trouble persists.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) hold_s_r <= '0;
		else if (!trouble) hold_s_r <= '0;
		else if (moving_stop_p) hold_s_r <= RUN_HOLD_S;
		else if (sec_tick && hold_s_r != 12'd0) hold_s_r <= hold_s_r - 12'd1;
	end

	// ==================================================================
	// Fault priority, display and motion
	// ==================================================================
	logic disable_all, disable_ord, show_nxt;
	logic [7:0] code_nxt;
	assign disable_all = entrap_r | runlim_r | run_h_r | dh_r | e08_r | b05_r | mm_r
		| s[IN_PEER_ENTRAP] | s[IN_MAINS_LOW] | s[IN_PEER_FW] | s[IN_NV] | s[IN_MOTOR];
	assign disable_ord = disable_all | link_lost;

	// The highest fault holds the display until it clears.
	always_comb begin
		show_nxt = 1'b1;
		code_nxt = FC_DD;
		if (runlim_r) code_nxt = runlim_open_r ? FC_D1 : FC_02;
		else if (run_h_r) code_nxt = FC_H;
		else if (e08_r) code_nxt = FC_08;
		else if (entrap_r) code_nxt = FC_DD;
		else if (s[IN_PEER_ENTRAP]) code_nxt = FC_06;
		else if (dh_r) code_nxt = FC_DH;
		else if (b05_r) code_nxt = FC_05;
		else if (link_lost) code_nxt = FC_D3;
		else if (s[IN_MAINS_LOW]) code_nxt = FC_DT;
		else if (s[IN_PEER_FW]) code_nxt = FC_09;
		else if (s[IN_NV]) code_nxt = FC_ID;
		else if (s[IN_MOTOR]) code_nxt = FC_12;
		else if (mm_r) code_nxt = FC_11;
		else if (s[IN_MAINS_LOST] && s[IN_IMM_PF]) code_nxt = FC_13;
		else show_nxt = 1'b0;
	end

	// ==================================================================
	// Sounder patterns
	// ==================================================================
	logic slow_on, fast_on, chirp_on, dbl_on, rate_on, beep_nxt;
	assign slow_on = ms_r < HALF_SEC_MS;
	assign fast_on = ms_r < QUARTER_SEC_MS || (ms_r >= HALF_SEC_MS && ms_r < THREE_QUARTER_MS);
	assign rate_on = trouble ? fast_on : slow_on;
	assign chirp_on = sec5_r == 3'd0 && ms_r < CHIRP_MS;
	assign dbl_on = sec5_r == 3'd0 && (ms_r < DBL_ON_MS ||
		(ms_r >= DBL_GAP_END_MS && ms_r < DBL_END_MS));

	// Continuous alarms win; the DH lockout is silent.
	always_comb begin
		if (entrap_r || runlim_r || link_alarm_r) beep_nxt = 1'b1;
		else if (s[IN_PRESTART]) beep_nxt = rate_on;
		else if (s[IN_MOVING] || hold_s_r != 12'd0) beep_nxt = rate_on;
		else if (remind_r) beep_nxt = dbl_on;
		else if (trouble) beep_nxt = chirp_on;
		else beep_nxt = 1'b0;
	end

	// ==================================================================
	// Registered outputs
	// ==================================================================
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fault_show <= 1'b0;
			fault_code <= FC_DD;
			link_lamp <= 1'b0;
			run_limit_lamp <= 1'b0;
			beeper <= 1'b0;
			gate_enable <= 1'b0;
			emergency_enable <= 1'b0;
			motor_stop <= 1'b1;
			failsafe_act <= 1'b0;
		end else begin
			fault_show <= show_nxt;
			fault_code <= code_nxt;
			link_lamp <= link_lost && slow_on;
			run_limit_lamp <= runlim_r;
			beeper <= beep_nxt;
			gate_enable <= !disable_ord;
			emergency_enable <= !disable_all;
			motor_stop <= entrap_r | runlim_r;
			failsafe_act <= b05_r;
		end
	end
endmodule : gfa_fault_manager

// *** dv/gfa_fault_manager_asserts.sv ***
module gfa_fault_manager_asserts
	import gfa_pkg::*;
(
	input wire logic clock, // System clock.
	input wire logic rstn, // Reset, active low.
	input wire logic stop_btn, // Stop press level.
	input wire logic dual_gate_enable, // Paired install.
	input wire logic peer_link_ok, // Peer link healthy.
	input wire logic peer_entrapment, // Peer lockout.
	input wire logic mains_low, // Mains below normal.
	input wire logic mains_lost, // Mains absent.
	input wire logic batt_below_min, // Battery low.
	input wire logic nv_fault, // Memory problem.
	input wire logic motor_fault, // Motor failure.
	input wire logic fault_show, // Code shown.
	input wire logic [7:0] fault_code, // Code value.
	input wire logic run_limit_lamp, // Run-limit lamp.
	input wire logic beeper, // Sounder.
	input wire logic gate_enable, // Motion permitted.
	input wire logic emergency_enable, // Emergency motion.
	input wire logic motor_stop // Motor forced off.
);
	// ==================================================================
	// Lockout and disable relations
	// ==================================================================
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	// Levels need eight stable cycles, the stop level in p_dh six; pins pass a synchroniser.
	property p_dd;
		fault_show && fault_code == FC_DD |-> beeper && !gate_enable && motor_stop;
	endproperty
	property p_runlim;
		fault_show && (fault_code == FC_D1 || fault_code == FC_02) |-> run_limit_lamp && !gate_enable;
	endproperty
	property p_link;
		(dual_gate_enable && !peer_link_ok) [*8] |=> ##1 !gate_enable;
	endproperty
	property p_peer;
		(dual_gate_enable && peer_entrapment) [*8] |-> ##2 !gate_enable;
	endproperty
	property p_mains;
		mains_low [*8] |-> ##2 fault_show && !gate_enable;
	endproperty
	property p_hw;
		(nv_fault || motor_fault) [*8] |=> ##1 !gate_enable;
	endproperty
	property p_batt;
		(mains_lost && batt_below_min) [*8] |-> ##2 !gate_enable;
	endproperty
	property p_dh;
		(!stop_btn) [*6] ##0 (fault_show && fault_code == FC_DH) |=> fault_show;
	endproperty
	a_dd: assert property (p_dd) else $error("DD lockout wrong");
	a_runlim: assert property (p_runlim) else $error("run limit wrong");
	a_link: assert property (p_link) else $error("link loss moves");
	a_peer: assert property (p_peer) else $error("peer lockout moves");
	a_mains: assert property (p_mains) else $error("low mains moves");
	a_hw: assert property (p_hw) else $error("hw fault moves");
	a_batt: assert property (p_batt) else $error("low battery moves");
	a_dh: assert property (p_dh) else $error("DH dropped early");
	c_dd: cover property (fault_show && fault_code == FC_DD);
	c_d1: cover property (fault_show && fault_code == FC_D1);
	c_dh: cover property (fault_show && fault_code == FC_DH);
	c_link: cover property (!gate_enable && emergency_enable);
endmodule : gfa_fault_manager_asserts

bind gfa_fault_manager gfa_fault_manager_asserts CHK (
	.clock(clock), .rstn(rstn), .stop_btn(stop_btn), .dual_gate_enable(dual_gate_enable),
	.peer_link_ok(peer_link_ok), .peer_entrapment(peer_entrapment), .mains_low(mains_low),
	.mains_lost(mains_lost), .batt_below_min(batt_below_min), .nv_fault(nv_fault),
	.motor_fault(motor_fault), .fault_show(fault_show), .fault_code(fault_code),
	.run_limit_lamp(run_limit_lamp), .beeper(beeper), .gate_enable(gate_enable),
	.emergency_enable(emergency_enable), .motor_stop(motor_stop)
);

// *** dv/gfa_peer_model.sv ***
module gfa_peer_model (
	input wire logic clock, // System clock.
	input wire logic rstn, // Reset, active low.
	input wire logic cut, // Cut the link.
	input wire logic obstr, // Peer obstruction level.
	input wire logic stop, // Peer stop press level.
	input wire logic fw_old, // Old peer firmware.
	output logic link_ok, // Link health.
	output logic entrap, // Peer in entrapment lockout.
	output logic fw_bad // Firmware mismatch.
);
	logic ob_r;
	logic st_r;
	logic [1:0] hits_r;
	// Link and firmware status lag one clock.
	always_ff @(posedge clock) begin
		link_ok <= !cut;
		fw_bad <= fw_old;
	end
	// A second obstruction locks the peer out until its stop.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ob_r <= 1'b0;
			st_r <= 1'b0;
			hits_r <= 2'h0;
			entrap <= 1'b0;
		end else begin
			ob_r <= obstr;
			st_r <= stop;
			if (stop && !st_r) begin
				hits_r <= 2'h0;
				entrap <= 1'b0;
			end else if (obstr && !ob_r) begin
				hits_r <= 2'h1;
				entrap <= entrap | (hits_r != 2'h0);
			end
		end
	end
endmodule : gfa_peer_model

// *** dv/gate_fault_alarm_manager_tb.sv ***
module gate_fault_alarm_manager_tb
	import gfa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STP = 0, RST = 1, OBS = 2, LIM = 3, CMD = 4, REX = 5, DCM = 6, POB = 7, PST = 8;
	localparam int MLO = 0, NVF = 1, MOF = 2, MLS = 3, BLO = 4, BOK = 5, IMM = 6, EMR = 7;
	localparam int FUL = 8, MOV = 9, OPN = 10, PRE = 11, DUA = 12, CUT = 13, FWO = 14;
	logic clock, rstn, link_ok, p_ent, fw_mm, fault_show, link_lamp, run_limit_lamp, beeper;
	logic gate_enable, emergency_enable, motor_stop, failsafe_act, q;
	logic [8:0] ev;
	logic [14:0] lv;
	logic [3:0] x_lb, x_tp;
	logic [7:0] fault_code;
	int failures, total_checks;
	gfa_fault_manager #(.TICK_CYC(2), .NXMTR(4)) DUT (
		.clock(clock), .rstn(rstn), .stop_btn(ev[STP]), .reset_btn(ev[RST]),
		.emergency_open_input(lv[EMR]), .dual_gate_enable(lv[DUA]), .peer_link_ok(link_ok),
		.peer_entrapment(p_ent), .peer_fw_mismatch(fw_mm), .run_time_expired(ev[REX]),
		.gate_opening(lv[OPN]), .gate_moving(lv[MOV]), .gate_fully_open(lv[FUL]),
		.obstruction_trig(ev[OBS]), .limit_reached(ev[LIM]), .command_in(ev[CMD]),
		.mains_low(lv[MLO]), .mains_lost(lv[MLS]), .batt_below_min(lv[BLO]),
		.batt_above_recover(lv[BOK]), .nv_fault(lv[NVF]), .motor_fault(lv[MOF]),
		.dc_motor_mismatch(ev[DCM]), .immediate_pf_mode(lv[IMM]), .prestart_active(lv[PRE]),
		.xmtr_enrolled(4'h1), .xmtr_report(4'h0), .xmtr_low_batt(x_lb), .xmtr_tamper(x_tp),
		.fault_show(fault_show), .fault_code(fault_code), .link_lamp(link_lamp),
		.run_limit_lamp(run_limit_lamp), .beeper(beeper), .gate_enable(gate_enable),
		.emergency_enable(emergency_enable), .motor_stop(motor_stop), .failsafe_act(failsafe_act)
	);
	gfa_peer_model PEER (
		.clock(clock), .rstn(rstn), .cut(lv[CUT]), .obstr(ev[POB]), .stop(ev[PST]),
		.fw_old(lv[FWO]), .link_ok(link_ok), .entrap(p_ent), .fw_bad(fw_mm)
	);
	// ==================================================================
	// Helpers
	// ==================================================================
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, seen);
			failures++;
		end
	endtask : chk
	task automatic chb(input string nm, input logic seen, input logic exp);
		chk(nm, {7'h00, seen}, {7'h00, exp});
	endtask : chb
	task automatic sc(input logic [7:0] c);
		chb("fault_show", fault_show, 1'b1);
		chk("fault_code", fault_code, c);
	endtask : sc
	// Events stand four clocks to pass the synchroniser.
	task automatic pl(input int k);
		ev[k] = 1'b1;
		cyc(4);
		ev[k] = 1'b0;
		cyc(6);
	endtask : pl
	task automatic set(input int k, input logic v);
		lv[k] = v;
		cyc(6);
	endtask : set
	function automatic logic sig(input bit s);
		return s ? link_lamp : beeper;
	endfunction : sig
	task automatic wl(input bit s, input logic v);
		int i;
		for (i = 0; i < 11000 && sig(s) !== v; i++) cyc(1);
		if (i == 11000) begin
			$display("Error wait expected %b seen timeout", v);
			failures++;
			give_verdict();
		end
	endtask : wl
	// Skip a pulse: the first beat may be partial.
	task automatic hl(input bit s, input bit skip, input int e);
		int n = 0;
		repeat (skip ? 2 : 1) begin
			wl(s, 1'b0);
			wl(s, 1'b1);
		end
		while (sig(s) === 1'b1 && n < 3000) begin
			n++;
			cyc(1);
		end
		chb("high_time", n >= e - 6 && n <= e + 6, 1'b1);
	endtask : hl
	task automatic quiet(input int lim, output logic hi);
		hi = 1'b0;
		repeat (lim) begin
			hi = hi | (beeper !== 1'b0);
			cyc(1);
		end
	endtask : quiet
	// ==================================================================
	// Scenarios
	// ==================================================================
	task automatic t_entrap;
		pl(OBS);
		pl(OBS);
		sc(FC_DD);
		chb("beeper", beeper, 1'b1);
		chb("motor_stop", motor_stop, 1'b1);
		pl(RST);
		chb("fault_show", fault_show, 1'b0);
		chb("motor_stop", motor_stop, 1'b0);
		chb("beeper", beeper, 1'b0);
		pl(LIM);
		pl(OBS);
		pl(OBS);
		pl(CMD);
		sc(FC_08);
		pl(RST);
		sc(FC_08);
		pl(STP);
		chb("gate_enable", gate_enable, 1'b1);
	endtask : t_entrap
	task automatic t_levels;
		logic [7:0] lc[3];
		lc = '{FC_DT, FC_ID, FC_12};
		for (int i = 0; i < 3; i++) begin
			set(i, 1'b1);
			sc(lc[i]);
			chb("gate_enable", gate_enable, 1'b0);
			set(i, 1'b0);
			chb("gate_enable", gate_enable, 1'b1);
		end
		lv[MLS] = 1'b1;
		set(BLO, 1'b1);
		sc(FC_05);
		chb("failsafe_act", failsafe_act, 1'b1);
		set(BLO, 1'b0);
		sc(FC_05);
		set(BOK, 1'b1);
		chb("gate_enable", gate_enable, 1'b1);
		set(IMM, 1'b1);
		sc(FC_13);
		set(MLS, 1'b0);
		chb("fault_show", fault_show, 1'b0);
		lv[IMM] = 1'b0;
		lv[BOK] = 1'b0;
		lv[MLS] = 1'b1;
		set(MOV, 1'b1);
		pl(REX);
		set(MOV, 1'b0);
		sc(FC_H);
		pl(STP);
		sc(FC_H);
		chb("gate_enable", gate_enable, 1'b0);
		set(BOK, 1'b1);
		chb("fault_show", fault_show, 1'b0);
		lv[MLS] = 1'b0;
		lv[BOK] = 1'b0;
		set(MOV, 1'b1);
		set(MOV, 1'b0);
		pl(DCM);
		sc(FC_11);
		pl(CMD);
		chb("fault_show", fault_show, 1'b0);
	endtask : t_levels
	task automatic t_emer;
		lv[EMR] = 1'b1;
		set(FUL, 1'b1);
		sc(FC_DH);
		lv[EMR] = 1'b0;
		set(FUL, 1'b0);
		pl(RST);
		sc(FC_DH);
		pl(STP);
		chb("fault_show", fault_show, 1'b0);
	endtask : t_emer
	task automatic t_peer;
		set(DUA, 1'b1);
		pl(POB);
		pl(POB);
		sc(FC_06);
		pl(PST);
		chb("gate_enable", gate_enable, 1'b1);
		set(FWO, 1'b1);
		sc(FC_09);
		set(FWO, 1'b0);
		set(CUT, 1'b1);
		sc(FC_D3);
		chb("beeper", beeper, 1'b1);
		chb("gate_enable", gate_enable, 1'b0);
		chb("emergency_enable", emergency_enable, 1'b1);
		hl(1'b1, 1'b1, 1000);
		pl(STP);
		chb("beeper", beeper, 1'b0);
		set(CUT, 1'b0);
		chb("gate_enable", gate_enable, 1'b1);
		set(DUA, 1'b0);
	endtask : t_peer
	task automatic t_run(input bit op);
		lv[OPN] = op;
		set(MOV, 1'b1);
		pl(REX);
		sc(op ? FC_D1 : FC_02);
		chb("run_limit_lamp", run_limit_lamp, 1'b1);
		chb("beeper", beeper, 1'b1);
		chb("motor_stop", motor_stop, 1'b1);
		set(MOV, 1'b0);
		pl(STP);
		hl(1'b0, 1'b0, 200);
		hl(1'b0, 1'b0, 200);
		set(MOV, 1'b1);
		set(MOV, 1'b0);
		if (op) begin
			quiet(10100, q);
			chb("beeper_quiet", q, 1'b0);
		end
	endtask : t_run
	task automatic t_trouble;
		lv[PRE] = 1'b1;
		hl(1'b0, 1'b1, 1000);
		x_lb[0] = 1'b1;
		hl(1'b0, 1'b1, 500);
		lv[PRE] = 1'b0;
		hl(1'b0, 1'b0, 100);
		x_lb[0] = 1'b0;
		x_tp[0] = 1'b1;
		hl(1'b0, 1'b1, 100);
		lv[MOV] = 1'b1;
		hl(1'b0, 1'b1, 500);
		lv[MOV] = 1'b0;
		hl(1'b0, 1'b1, 500);
		x_tp[0] = 1'b0;
		cyc(8);
		quiet(10100, q);
		chb("beeper_quiet", q, 1'b0);
	endtask : t_trouble
	task automatic give_verdict;
		$display("Checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict
	// Free-running 100 MHz clock.
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Inputs change on falling edges.
	initial begin
		rstn = 1'b0;
		ev = '0;
		lv = '0;
		x_lb = 4'h0;
		x_tp = 4'h0;
		failures = 0;
		total_checks = 0;
		cyc(10);
		rstn = 1'b1;
		cyc(8);
		t_entrap();
		t_levels();
		t_emer();
		t_peer();
		t_run(1'b1);
		t_run(1'b0);
		t_trouble();
		give_verdict();
	end
endmodule : gate_fault_alarm_manager_tb
